// ==== bench/fdr_desc_rom_tb_top.sv ====
// Purpose: self-checking bench of the descriptor store
// Assumes: expected bytes are rebuilt here from the endpoint layout
// Notes: driver queues {last, byte}; monitor pops on each handshake
`timescale 1ns/1ps
`default_nettype none
module fdr_desc_rom_tb_top;
  import fdr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  fdr_req_t req_i = '0;
  logic stall_en = 1'b0;
  logic req_ready_o, byte_valid_o, byte_last_o, byte_ready_i;
  logic [7:0] byte_o;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 29644;

  fdr_desc_rom i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .byte_valid_o(byte_valid_o), .byte_o(byte_o),
    .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i));
  fdr_host_model i_host (.mclk_i(mclk_i), .stall_en_i(stall_en), .byte_ready_o(byte_ready_i));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] exp_byte(int idx);
    logic [7:0] ea [6] = '{8'h01, 8'h81, 8'h02, 8'h04, 8'h86, 8'h88};
    logic [7:0] ifd [9] = '{8'h09, 8'h04, 8'h00, 8'h02, 8'h06, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    int i;
    logic irq;
    if (idx >= 42 && idx <= 50) return ifd[idx - 42];
    i = (idx > 50) ? idx - 51 : idx;
    // ep4 and ep8 stay bulk in alt 2
    irq = idx > 50 && i / 7 != 3 && i / 7 != 5;
    case (i % 7)
      0: return 8'h07;
      1: return 8'h05;
      2: return ea[i / 7];
      3: return irq ? 8'h03 : 8'h02;
      4: return 8'h40;
      6: return irq ? 8'h0A : 8'h00;
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // queue the stream, present the request, poke while busy if asked
  task automatic send(logic [6:0] start, logic [15:0] len, bit poke);
    int n;
    n = (start > 92) ? 0 : ((len < 93 - start) ? int'(len) : 93 - start);
    for (int k = 0; k < n; k++) exp_q.push_back({k == n - 1, exp_byte(start + k)});
    @(negedge mclk_i);
    req_valid_i = 1'b1;
    req_i = '{start: start, len: len};
    @(negedge mclk_i);
    req_valid_i = poke;
    req_i = '{start: 7'h00, len: 16'h0001};
    repeat (3) @(negedge mclk_i);
    req_valid_i = 1'b0;
    for (int t = 0; t < 2000 && exp_q.size() != 0; t++) @(negedge mclk_i);
    @(negedge mclk_i);
    chk("bytes left", 16'h0000, 16'(exp_q.size()));
    exp_q.delete();
    chk("ready after stream", 16'h0001, {15'h0000, req_ready_o});
  endtask : send

  always @(posedge mclk_i) begin
    if (!rst_i && byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected byte", 16'h0000, {8'h01, byte_o});
      else chk("last and byte", {7'h00, exp_q.pop_front()}, {7'h00, byte_last_o, byte_o});
    end
  end

  initial begin
    #200us;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    chk("idle after reset", 16'h0002, {14'h0000, req_ready_o, byte_valid_o});
    stall_en = 1'b1;
    // whole store under stalls, with ignored requests while busy
    send(7'h00, 16'h0100, 1'b1);
    stall_en = 1'b0;
    send(7'h00, 16'h0002, 1'b0);
    send(7'h28, 16'h0005, 1'b0);
    send(7'h2A, 16'h0001, 1'b0);
    send(7'h58, 16'hFFFF, 1'b0);
    send(7'h10, 16'h0000, 1'b0);
    send(7'h5D, 16'h0004, 1'b0);
    for (int r = 0; r < 24; r++) begin
      stall_en = $random(seed) & 32'h0000_0001;
      send(7'(($random(seed) & 32'h7FFF_FFFF) % 94), 16'($random(seed) & 32'h0000_001F), 1'b0);
    end
    close_out();
  end
endmodule : fdr_desc_rom_tb_top
`default_nettype wire

// ==== bench/fdr_host_model.sv ====
// Purpose: host side consumer of descriptor bytes
// Assumes: a byte is taken on a rising edge with valid and ready high
// Notes: random stalls while stall_en_i is high
`timescale 1ns/1ps
`default_nettype none
module fdr_host_model (
  input wire logic mclk_i,
  input wire logic stall_en_i,
  output logic byte_ready_o
);
  int seed = 29644;
  initial byte_ready_o = 1'b0;
  // host pulls at its own pace
  always @(negedge mclk_i) begin
    byte_ready_o <= !stall_en_i || (($random(seed) & 32'h0000_0001) != 0);
  end
endmodule : fdr_host_model
`default_nettype wire

// ==== rtl/fdr_cfg.svh ====
// Purpose: constants of the full-speed alternate setting descriptor store
// Assumes: byte-wide descriptor store, indices count from the first alt 1 endpoint byte
// Notes: definitions only
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH

// store layout
`define FDR_DEPTH 93
`define FDR_IDX_ALT2_IF 7'h2A
`define FDR_IDX_ALT2_EP 7'h33
`define FDR_IDX_LAST 7'h5C
`define FDR_EP_BYTES 7
`define FDR_EP_COUNT 6

// endpoint descriptor fields
`define FDR_EP_LEN 8'h07
`define FDR_EP_TYPE 8'h05
`define FDR_OFF_LEN 0
`define FDR_OFF_TYPE 1
`define FDR_OFF_ADDR 2
`define FDR_OFF_ATTR 3
`define FDR_OFF_MPS_L 4
`define FDR_OFF_MPS_H 5
`define FDR_OFF_IVL 6
`define FDR_MPS_L 8'h40
`define FDR_MPS_H 8'h00
`define FDR_XFR_BULK 8'h02
`define FDR_XFR_INT 8'h03
`define FDR_IVL_BULK 8'h00
`define FDR_IVL_INT 8'h0A
`define FDR_DIR_IN_BIT 7

// endpoint addresses in serving order
`define FDR_EA_OUT1 8'h01
`define FDR_EA_IN1 8'h81
`define FDR_EA_OUT2 8'h02
`define FDR_EA_OUT4 8'h04
`define FDR_EA_IN6 8'h86
`define FDR_EA_IN8 8'h88
`define FDR_SLOT_EP4 3
`define FDR_SLOT_EP8 5

// alt 2 interface descriptor
`define FDR_IF_LEN 8'h09
`define FDR_IF_TYPE 8'h04
`define FDR_IF_NUM 8'h00
`define FDR_IF_ALT2 8'h02
`define FDR_IF_NUM_EP 8'h06
`define FDR_IF_VENDOR 8'hFF
`define FDR_IF_NO_STR 8'h00

`endif

// ==== rtl/fdr_desc_rom.sv ====
// Purpose: fixed store of full-speed endpoint descriptors for interface 0 alt 1 and alt 2
// Assumes: a control engine requests a start index and the host wLength
// Notes: bytes leave one per valid/ready handshake, in stored order
// How it works
// [R1] every endpoint descriptor is seven bytes: 07H length, 05H type
// [R2] address bit 7 marks IN; codes 01H 81H 02H 04H 86H 88H
// [R3] max packet 64 bytes: 40H at offset four, 00H at five
// [R4] alt 1 endpoints are all bulk 02H with interval 00H
// [R5] fields: address, attributes, packet size low/high, interval at offsets 2..6
// [R6] alt 2 interface: nine bytes, type 04H, alt 02H, six endpoints, FFH class
// [R7] alt 2: EP1 out/in, EP2, EP6 interrupt 03H interval 0AH; EP4 and EP8 bulk
// [R8] endpoints follow interface in order 1 OUT, 1 IN, 2, 4, 6, 8
// [R9] bytes are fixed logic and leave exactly in stored order
// [R10] host asks by control transfer; stream stops at requested length
`timescale 1ns/1ps
`default_nettype none
`include "fdr_cfg.svh"

module fdr_desc_rom
  import fdr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire fdr_req_t req_i,
  output logic req_ready_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic byte_last_o,
  input wire logic byte_ready_i
);

  // [R1] [R2] [R3] [R5] [R6] [R7] [R8] byte contents by index
  function automatic logic [7:0] fdr_rom_byte(input int idx);
    int rel;
    int slot;
    int off;
    logic alt2;
    logic [7:0] b;
    alt2 = (idx >= int'(`FDR_IDX_ALT2_IF));
    rel = (idx >= int'(`FDR_IDX_ALT2_EP)) ? idx - int'(`FDR_IDX_ALT2_EP) : idx;
    slot = rel / `FDR_EP_BYTES;
    off = rel % `FDR_EP_BYTES;
    b = 8'h00;
    if (alt2 && idx < int'(`FDR_IDX_ALT2_EP)) begin
      case (idx - int'(`FDR_IDX_ALT2_IF))
        0: b = `FDR_IF_LEN;
        1: b = `FDR_IF_TYPE;
        2: b = `FDR_IF_NUM;
        3: b = `FDR_IF_ALT2;
        4: b = `FDR_IF_NUM_EP;
        5, 6, 7: b = `FDR_IF_VENDOR;
        default: b = `FDR_IF_NO_STR;
      endcase
    end else begin
      case (off)
        `FDR_OFF_LEN: b = `FDR_EP_LEN;
        `FDR_OFF_TYPE: b = `FDR_EP_TYPE;
        `FDR_OFF_ADDR: begin
          case (slot)
            0: b = `FDR_EA_OUT1;
            1: b = `FDR_EA_IN1;
            2: b = `FDR_EA_OUT2;
            3: b = `FDR_EA_OUT4;
            4: b = `FDR_EA_IN6;
            default: b = `FDR_EA_IN8;
          endcase
        end
        `FDR_OFF_ATTR: begin
          b = (alt2 && slot != `FDR_SLOT_EP4 && slot != `FDR_SLOT_EP8) ? `FDR_XFR_INT : `FDR_XFR_BULK;
        end
        `FDR_OFF_MPS_L: b = `FDR_MPS_L;
        `FDR_OFF_MPS_H: b = `FDR_MPS_H;
        default: begin
          b = (alt2 && slot != `FDR_SLOT_EP4 && slot != `FDR_SLOT_EP8) ? `FDR_IVL_INT : `FDR_IVL_BULK;
        end
      endcase
    end
    return b;
  endfunction : fdr_rom_byte

  logic [7:0] rom [`FDR_DEPTH];

  // [R9] constant store, one entry per index
  for (genvar g = 0; g < `FDR_DEPTH; g++) begin : g_rom
    assign rom[g] = fdr_rom_byte(g);
  end

  fdr_state_t state_reg, state_next;
  logic [6:0] ptr_reg, ptr_next;
  logic [15:0] rem_reg, rem_next;
  logic [7:0] data_reg, data_next;
  logic at_end;

  assign at_end = (rem_reg == 16'h0001) || (ptr_reg == `FDR_IDX_LAST);
  assign req_ready_o = (state_reg == st_idle);
  assign byte_valid_o = (state_reg == st_send);
  assign byte_o = data_reg;
  assign byte_last_o = byte_valid_o && at_end;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    rem_next = rem_reg;
    data_next = data_reg;
    case (state_reg)
      st_idle: begin
        // [R10] zero length or start past the end sends nothing
        if (req_valid_i && req_i.len != 16'h0000 && req_i.start <= `FDR_IDX_LAST) begin
          state_next = st_send;
          ptr_next = req_i.start;
          rem_next = req_i.len;
          data_next = rom[req_i.start];
        end
      end
      default: begin
        if (byte_ready_i) begin
          // [R10] truncate at requested length
          if (at_end) begin
            state_next = st_idle;
          end else begin
            // [R9] next stored byte
            ptr_next = 7'(ptr_reg + 7'h01);
            rem_next = 16'(rem_reg - 16'h0001);
            data_next = rom[7'(ptr_reg + 7'h01)];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= st_idle;
      ptr_reg <= 7'h00;
      rem_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      rem_reg <= rem_next;
      data_reg <= data_next;
    end
  end

  // checking helpers: where the byte on the port sits in its descriptor
  int ep_rel;
  int ep_slot;
  int ep_off;
  logic in_ep;
  logic in_alt2;
  always_comb begin
    in_alt2 = (ptr_reg >= `FDR_IDX_ALT2_EP);
    in_ep = (ptr_reg < `FDR_IDX_ALT2_IF) || in_alt2;
    ep_rel = in_alt2 ? int'(ptr_reg) - int'(`FDR_IDX_ALT2_EP) : int'(ptr_reg);
    ep_slot = ep_rel / `FDR_EP_BYTES;
    ep_off = ep_rel % `FDR_EP_BYTES;
  end

  property p_ep_header;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_LEN |-> byte_o == `FDR_EP_LEN;
  endproperty
  a_ep_header: assert property (p_ep_header) else $error("endpoint length byte wrong"); // [R1]

  property p_ep_type;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_TYPE |-> byte_o == `FDR_EP_TYPE;
  endproperty
  a_ep_type: assert property (p_ep_type) else $error("endpoint type byte wrong"); // [R1]

  property p_dir_bit;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_ADDR |->
      byte_o[`FDR_DIR_IN_BIT] == (ep_slot == 1 || ep_slot == 4 || ep_slot == 5);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("endpoint direction bit wrong"); // [R2]

  property p_mps;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_MPS_L && byte_ready_i && !byte_last_o |->
      byte_o == `FDR_MPS_L ##1 byte_o == `FDR_MPS_H;
  endproperty
  a_mps: assert property (p_mps) else $error("max packet size bytes wrong"); // [R3]

  property p_alt1_bulk;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && ptr_reg < `FDR_IDX_ALT2_IF && ep_off == `FDR_OFF_ATTR && byte_ready_i && !byte_last_o |->
      byte_o == `FDR_XFR_BULK ##1 byte_o == `FDR_MPS_L;
  endproperty
  a_alt1_bulk: assert property (p_alt1_bulk) else $error("alt 1 endpoint not bulk"); // [R4]

  property p_interval;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_IVL |->
      byte_o == ((in_alt2 && ep_slot != `FDR_SLOT_EP4 && ep_slot != `FDR_SLOT_EP8) ? `FDR_IVL_INT : `FDR_IVL_BULK);
  endproperty
  a_interval: assert property (p_interval) else $error("polling interval wrong"); // [R4]

  property p_addr_field;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_ADDR |->
      byte_o[3:0] != 4'h0 && byte_o[6:4] == 3'h0;
  endproperty
  a_addr_field: assert property (p_addr_field) else $error("address not at offset two"); // [R5]

  property p_alt2_if;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && ptr_reg == `FDR_IDX_ALT2_IF |->
      byte_o == `FDR_IF_LEN;
  endproperty
  a_alt2_if: assert property (p_alt2_if) else $error("alt 2 interface length wrong"); // [R6]

  property p_alt2_count;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && ptr_reg == 7'(`FDR_IDX_ALT2_IF + 7'h04) |-> byte_o == `FDR_IF_NUM_EP;
  endproperty
  a_alt2_count: assert property (p_alt2_count) else $error("alt 2 endpoint count wrong"); // [R6]

  property p_alt2_type;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_alt2 && ep_off == `FDR_OFF_ATTR |->
      byte_o == ((ep_slot == `FDR_SLOT_EP4 || ep_slot == `FDR_SLOT_EP8) ? `FDR_XFR_BULK : `FDR_XFR_INT);
  endproperty
  a_alt2_type: assert property (p_alt2_type) else $error("alt 2 transfer type wrong"); // [R7]

  property p_ep_order;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && in_ep && ep_off == `FDR_OFF_ADDR && ep_slot == `FDR_SLOT_EP4 |-> byte_o == `FDR_EA_OUT4;
  endproperty
  a_ep_order: assert property (p_ep_order) else $error("endpoint order wrong"); // [R8]

  property p_seq;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && byte_ready_i && !byte_last_o |=>
      byte_valid_o && ptr_reg == 7'($past(ptr_reg) + 7'h01);
  endproperty
  a_seq: assert property (p_seq) else $error("bytes not in stored order"); // [R9]

  property p_trunc;
    @(posedge mclk_i) disable iff (rst_i)
    req_valid_i && req_ready_o && req_i.len == 16'h0001 && req_i.start <= `FDR_IDX_LAST |=>
      byte_valid_o && byte_last_o;
  endproperty
  a_trunc: assert property (p_trunc) else $error("single byte request not last"); // [R10]

  property p_end;
    @(posedge mclk_i) disable iff (rst_i)
    byte_valid_o && byte_ready_i && byte_last_o |=> !byte_valid_o && req_ready_o;
  endproperty
  a_end: assert property (p_end) else $error("stream ran past its end"); // [R10]

endmodule : fdr_desc_rom

`default_nettype wire

// ==== rtl/fdr_pkg.sv ====
// Purpose: types of the full-speed alternate setting descriptor store
// Assumes: nothing beyond the cfg header
// Notes: request and state types only
package fdr_pkg;
  typedef struct packed {
    logic [6:0] start;
    logic [15:0] len;
  } fdr_req_t;

  typedef enum logic {
    st_idle,
    st_send
  } fdr_state_t;
endpackage : fdr_pkg
